// File: verilog/cbs_pkg.sv
/*
 Package for the bus cycle sequencer: opcode encodings, vector address,
 stack frame size, and the bus cycle carrier struct.
 Assumes a single 100 MHz clock domain; one machine cycle per clock.
*/
package cbs_pkg;

   // ==========================================================
   // Opcodes decoded into instruction classes
   // ==========================================================
   localparam logic [7:0] OP_SOFT_TRAP = 8'h3F;
   localparam logic [7:0] OP_WAIT_INT = 8'h3E;
   localparam logic [7:0] OP_JUMP_EXT = 8'h7E;
   localparam logic [7:0] OP_CALL_EXT = 8'hBD;
   localparam logic [7:0] OP_TEST_EXT = 8'h7D;
   localparam logic [7:0] OP_CMPX_IMM = 8'h8C;
   localparam logic [7:0] OP_LDS_IMM = 8'h8E;
   localparam logic [7:0] OP_LDX_IMM = 8'hCE;
   localparam logic [7:0] OP_CMPX_DIR = 8'h9C;
   localparam logic [7:0] OP_LDS_DIR = 8'h9E;
   localparam logic [7:0] OP_LDX_DIR = 8'hDE;
   localparam logic [7:0] OP_STS_DIR = 8'h9F;
   localparam logic [7:0] OP_STX_DIR = 8'hDF;
   localparam logic [7:0] OP_STA_DIR = 8'h97;
   localparam logic [7:0] OP_STB_DIR = 8'hD7;
   localparam logic [7:0] OP_CMPX_EXT = 8'hBC;
   localparam logic [7:0] OP_LDS_EXT = 8'hBE;
   localparam logic [7:0] OP_LDX_EXT = 8'hFE;
   localparam logic [7:0] OP_STS_EXT = 8'hBF;
   localparam logic [7:0] OP_STX_EXT = 8'hFF;
   localparam logic [7:0] OP_STA_EXT = 8'hB7;
   localparam logic [7:0] OP_STB_EXT = 8'hF7;

   // ==========================================================
   // Addresses and counts
   // ==========================================================
   localparam logic [15:0] SOFT_TRAP_VECTOR = 16'hFFFA;
   localparam logic [15:0] STACK_FRAME_LEN = 16'h0007;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] RESET_SP = 16'h01FF;
   localparam logic [7:0] CC_MASK_BIT = 8'h10;
   localparam logic [7:0] CC_RESET = 8'hD0;

   // ==========================================================
   // Instruction flow classes and bus cycle carrier
   // ==========================================================
   typedef enum {
      CL_IMM8, CL_IMM16, CL_DIR8, CL_DIR16, CL_DIRST8, CL_DIRST16,
      CL_EXT8, CL_EXT16, CL_EXTST8, CL_EXTST16, CL_RMW, CL_TEST,
      CL_JUMP, CL_CALL, CL_BRANCH, CL_TRAP, CL_WAIT, CL_IMPL
   } cbs_class_t;

   typedef struct packed {
      logic [15:0] addr;
      logic valid;
      logic rd_wr_n;
      logic [7:0] wdata;
   } cbs_bus_t;

endpackage : cbs_pkg

// File: verilog/cbs_branch_calc.sv
/*
 Relative branch target calculator.
 Assumes the opcode address is stable while the offset is applied.
*/
`timescale 1ns/10ps
module cbs_branch_calc (
   input wire logic [15:0] op_addr_i,
   input wire logic [7:0] offset_i,
   output logic [15:0] target_o
);
   import cbs_pkg::*;

   logic [15:0] next_pc;
   logic [15:0] sext;

   // ==========================================================
   // Signed offset added to the address after the two bytes
   // ==========================================================
   always_comb begin
      sext = {{8{offset_i[7]}}, offset_i};
      next_pc = op_addr_i + 16'h0002;
      target_o = next_pc + sext;
   end

endmodule : cbs_branch_calc

// File: verilog/cbs_sequencer.sv
/*
 Cycle by cycle bus sequencer for an 8-bit processor core.
 Assumes memory answers reads in the same cycle (data sampled at the
 clock edge that ends the cycle) and that the core datapath supplies
 register values and branch decisions on plain inputs.
*/
`timescale 1ns/10ps
module cbs_sequencer (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] rdata_i,
   input wire logic irq_i,
   input wire logic branch_take_i,
   input wire logic [7:0] accum_a_i,
   input wire logic [7:0] accum_b_i,
   input wire logic [15:0] index_i,
   input wire logic [7:0] cc_i,
   input wire logic [7:0] alu_result_i,
   output cbs_pkg::cbs_bus_t bus_o,
   output logic addr_oe_o,
   output logic data_oe_o,
   output logic bus_granted_o,
   output logic [15:0] pc_o,
   output logic [15:0] sp_o,
   output logic [15:0] operand_o,
   output logic cc_mask_set_o,
   output logic instr_done_o
);
   import cbs_pkg::*;

   typedef enum {ST_FETCH, ST_EXEC, ST_WAIT} cbs_state_t;

   cbs_state_t state;
   cbs_class_t cls;
   logic [7:0] opcode;
   logic [3:0] cyc;
   logic [15:0] pc;
   logic [15:0] sp;
   logic [15:0] op_addr;
   logic [15:0] ea;
   logic [15:0] operand;
   logic [7:0] offset;
   logic [15:0] br_target;
   cbs_bus_t next_bus;
   logic last;
   cbs_class_t dec_cls;

   cbs_branch_calc u_branch (
      .op_addr_i(op_addr),
      .offset_i(offset),
      .target_o(br_target)
   );

   // ==========================================================
   // Opcode class decode
   // ==========================================================
   function automatic cbs_class_t decode(input logic [7:0] op);
      cbs_class_t c;
      c = CL_IMPL;
      if (op[7:4] == 4'h2) c = CL_BRANCH;
      else if (op == OP_SOFT_TRAP) c = CL_TRAP;
      else if (op == OP_WAIT_INT) c = CL_WAIT;
      else if (op == OP_JUMP_EXT) c = CL_JUMP;
      else if (op == OP_CALL_EXT) c = CL_CALL;
      else if (op == OP_TEST_EXT) c = CL_TEST;
      else if (op == OP_CMPX_IMM || op == OP_LDS_IMM || op == OP_LDX_IMM)
         c = CL_IMM16;
      else if (op == OP_CMPX_DIR || op == OP_LDS_DIR || op == OP_LDX_DIR)
         c = CL_DIR16;
      else if (op == OP_STS_DIR || op == OP_STX_DIR) c = CL_DIRST16;
      else if (op == OP_STA_DIR || op == OP_STB_DIR) c = CL_DIRST8;
      else if (op == OP_CMPX_EXT || op == OP_LDS_EXT || op == OP_LDX_EXT)
         c = CL_EXT16;
      else if (op == OP_STS_EXT || op == OP_STX_EXT) c = CL_EXTST16;
      else if (op == OP_STA_EXT || op == OP_STB_EXT) c = CL_EXTST8;
      else if (op[7:4] == 4'h7) c = CL_RMW;
      else if (op[7] && op[5:4] == 2'b00) c = CL_IMM8;
      else if (op[7] && op[5:4] == 2'b01) c = CL_DIR8;
      else if (op[7] && op[5:4] == 2'b11) c = CL_EXT8;
      return c;
   endfunction : decode

   assign dec_cls = decode(rdata_i);

   // ==========================================================
   // Bus cycle generation
   // ==========================================================
   always_comb begin
      next_bus = '{addr: pc, valid: 1'b1, rd_wr_n: 1'b1, wdata: 8'h00};
      last = 1'b0;
      if (state == ST_EXEC) begin
         unique case (cls)
            CL_IMM8: begin
               next_bus.addr = op_addr + 16'h0001;
               last = 1'b1;
            end
            CL_IMM16: begin
               next_bus.addr = op_addr + {12'h000, cyc - 4'h1};
               last = (cyc == 4'h3);
            end
            CL_DIR8, CL_DIR16, CL_DIRST8, CL_DIRST16: begin
               if (cyc == 4'h2) begin
                  next_bus.addr = op_addr + 16'h0001;
               end else if (cls == CL_DIR8 || cls == CL_DIR16) begin
                  next_bus.addr = ea + {12'h000, cyc - 4'h3};
                  last = (cls == CL_DIR8) ? 1'b1 : (cyc == 4'h4);
               end else if (cyc == 4'h3) begin
                  next_bus.addr = ea;
                  next_bus.valid = 1'b0;
               end else begin
                  next_bus.addr = ea + {12'h000, cyc - 4'h4};
                  next_bus.rd_wr_n = 1'b0;
                  next_bus.wdata = (cls == CL_DIRST8) ?
                     (opcode[6] ? accum_b_i : accum_a_i) :
                     (cyc == 4'h4 ? operand[15:8] : operand[7:0]);
                  last = (cls == CL_DIRST8) || (cyc == 4'h5);
               end
            end
            CL_TRAP: begin
               unique case (cyc)
                  4'h2: next_bus.addr = op_addr + 16'h0001;
                  4'hA: begin
                     next_bus.addr = sp;
                     next_bus.valid = 1'b0;
                  end
                  4'hB: next_bus.addr = SOFT_TRAP_VECTOR;
                  4'hC: begin
                     next_bus.addr = SOFT_TRAP_VECTOR + 16'h0001;
                     last = 1'b1;
                  end
                  default: begin
                     next_bus.addr = sp;
                     next_bus.rd_wr_n = 1'b0;
                     unique case (cyc)
                        4'h3: next_bus.wdata = pc[7:0];
                        4'h4: next_bus.wdata = pc[15:8];
                        4'h5: next_bus.wdata = index_i[7:0];
                        4'h6: next_bus.wdata = index_i[15:8];
                        4'h7: next_bus.wdata = accum_a_i;
                        4'h8: next_bus.wdata = accum_b_i;
                        default: next_bus.wdata = cc_i;
                     endcase
                  end
               endcase
            end
            CL_BRANCH: begin
               next_bus.addr = (cyc == 4'h4) ? br_target :
                  op_addr + {12'h000, cyc - 4'h1};
               next_bus.valid = (cyc == 4'h2);
               last = (cyc == 4'h4);
            end
            CL_WAIT, CL_IMPL: begin
               next_bus.addr = op_addr + 16'h0001;
               last = 1'b1;
            end
            default: begin
               // Extended forms share three fetch cycles.
               if (cyc <= 4'h3) begin
                  next_bus.addr = op_addr + {12'h000, cyc - 4'h1};
                  last = (cls == CL_JUMP) && (cyc == 4'h3);
               end else begin
                  unique case (cls)
                     CL_EXT8, CL_EXT16: begin
                        next_bus.addr = ea + {12'h000, cyc - 4'h4};
                        last = (cls == CL_EXT8) || (cyc == 4'h5);
                     end
                     CL_EXTST8, CL_EXTST16: begin
                        next_bus.addr = ea + {12'h000,
                           (cyc == 4'h6) ? 4'h1 : 4'h0};
                        next_bus.valid = (cyc != 4'h4);
                        next_bus.rd_wr_n = (cyc == 4'h4);
                        next_bus.wdata = (cls == CL_EXTST8) ?
                           (opcode[6] ? accum_b_i : accum_a_i) :
                           (cyc == 4'h5 ? operand[15:8] : operand[7:0]);
                        last = (cls == CL_EXTST8) ? (cyc == 4'h5) :
                           (cyc == 4'h6);
                     end
                     CL_RMW, CL_TEST: begin
                        next_bus.addr = ea;
                        next_bus.valid = (cyc == 4'h4) ||
                           (cyc == 4'h6 && cls == CL_RMW);
                        next_bus.rd_wr_n = !(cyc == 4'h6 && cls == CL_RMW);
                        next_bus.wdata = alu_result_i;
                        last = (cyc == 4'h6);
                     end
                     default: begin
                        // Call: dummy read, two pushes, three idle cycles.
                        unique case (cyc)
                           4'h4: next_bus.addr = ea;
                           4'h5, 4'h6: begin
                              next_bus.addr = sp;
                              next_bus.rd_wr_n = 1'b0;
                              next_bus.wdata = (cyc == 4'h5) ?
                                 pc[7:0] : pc[15:8];
                           end
                           4'h7: begin
                              next_bus.addr = sp;
                              next_bus.valid = 1'b0;
                           end
                           default: begin
                              next_bus.addr = op_addr + 16'h0002;
                              next_bus.valid = 1'b0;
                              last = (cyc == 4'h9);
                           end
                        endcase
                     end
                  endcase
               end
            end
         endcase
      end
      if (state == ST_WAIT) begin
         next_bus.valid = 1'b0;
      end
   end

   // ==========================================================
   // Sequencing state
   // ==========================================================
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state <= ST_FETCH;
         cls <= CL_IMPL;
         opcode <= 8'h00;
         cyc <= 4'h1;
         op_addr <= RESET_PC;
      end else begin
         unique case (state)
            ST_FETCH: begin
               opcode <= rdata_i;
               cls <= dec_cls;
               op_addr <= pc;
               cyc <= 4'h2;
               state <= ST_EXEC;
            end
            ST_EXEC: begin
               cyc <= cyc + 4'h1;
               if (last) begin
                  cyc <= 4'h1;
                  state <= (cls == CL_WAIT) ? ST_WAIT : ST_FETCH;
               end
            end
            ST_WAIT: begin
               if (irq_i) begin
                  state <= ST_FETCH;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Program counter, stack pointer, address and operand latch
   // ==========================================================
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         pc <= RESET_PC;
         sp <= RESET_SP;
         ea <= 16'h0000;
         operand <= 16'h0000;
         offset <= 8'h00;
         cc_mask_set_o <= 1'b0;
      end else begin
         cc_mask_set_o <= 1'b0;
         if (state == ST_FETCH) begin
            pc <= pc + 16'h0001;
            operand <= (dec_cls == CL_DIRST16 || dec_cls == CL_EXTST16) ?
               (rdata_i[6] ? index_i : sp) : 16'h0000;
         end else if (state == ST_EXEC) begin
            unique case (cls)
               CL_IMM8, CL_IMM16: begin
                  pc <= pc + 16'h0001;
                  operand <= {operand[7:0], rdata_i};
               end
               CL_DIR8, CL_DIR16, CL_DIRST8, CL_DIRST16: begin
                  if (cyc == 4'h2) begin
                     pc <= pc + 16'h0001;
                     ea <= {8'h00, rdata_i};
                  end else if (next_bus.rd_wr_n && next_bus.valid) begin
                     operand <= {operand[7:0], rdata_i};
                  end
               end
               CL_TRAP: begin
                  if (cyc >= 4'h3 && cyc <= 4'h9) begin
                     sp <= sp - 16'h0001;
                  end
                  if (cyc == 4'hB) begin
                     ea[15:8] <= rdata_i;
                  end
                  if (cyc == 4'hC) begin
                     pc <= {ea[15:8], rdata_i};
                     cc_mask_set_o <= 1'b1;
                  end
               end
               CL_BRANCH: begin
                  if (cyc == 4'h2) begin
                     offset <= rdata_i;
                     pc <= pc + 16'h0001;
                  end
                  if (cyc == 4'h4 && branch_take_i) begin
                     pc <= br_target;
                  end
               end
               CL_WAIT, CL_IMPL: begin
               end
               default: begin
                  if (cyc == 4'h2) begin
                     ea[15:8] <= rdata_i;
                     pc <= pc + 16'h0001;
                  end else if (cyc == 4'h3) begin
                     ea[7:0] <= rdata_i;
                     pc <= pc + 16'h0001;
                     if (cls == CL_JUMP) begin
                        pc <= {ea[15:8], rdata_i};
                     end
                  end else if (cls == CL_EXT8 || cls == CL_EXT16 ||
                     ((cls == CL_RMW || cls == CL_TEST) && cyc == 4'h4)) begin
                     operand <= {operand[7:0], rdata_i};
                  end else if (cls == CL_CALL) begin
                     if (cyc == 4'h5 || cyc == 4'h6) begin
                        sp <= sp - 16'h0001;
                     end
                     if (cyc == 4'h9) begin
                        pc <= ea;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Bus outputs
   // ==========================================================
   // The pins show the cycle being worked on, so read data taken at the
   // closing edge belong to the address shown; a register here would let
   // every read answer the previous address.
   always_comb begin
      bus_o = next_bus;
      if (!rst_b_i) begin
         bus_o = '{addr: 16'h0000, valid: 1'b0, rd_wr_n: 1'b1,
            wdata: 8'h00};
      end
   end

   // The bus is released in the wait state so another master may use it.
   assign bus_granted_o = (state == ST_WAIT);
   assign addr_oe_o = (state != ST_WAIT);
   assign data_oe_o = (state != ST_WAIT) && !bus_o.rd_wr_n;
   assign pc_o = pc;
   assign sp_o = sp;
   assign operand_o = operand;
   assign instr_done_o = (state == ST_EXEC) && last;

endmodule : cbs_sequencer

// File: verification/cbs_mem_model.sv
/*
 Memory on the far side of the sequencer bus.
 Assumes reads answer the address shown on bus_o in the same cycle.
*/
`timescale 1ns/10ps
module cbs_mem_model (
   input wire logic mclk_i,
   input wire cbs_pkg::cbs_bus_t bus_i,
   input wire logic addr_oe_i,
   input wire logic data_oe_i,
   output logic [7:0] rdata_o
);
   import cbs_pkg::*;
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   // Floating data shows the inverse of the last byte, never a stale copy.
   assign rdata_o = (bus_i.valid && bus_i.rd_wr_n && addr_oe_i) ?
      mem[bus_i.addr] : ~last;
   initial begin
      foreach (mem[i]) begin
         mem[i] = 8'h3C;
      end
   end
   always @(posedge mclk_i) begin
      last <= rdata_o;
      if (bus_i.valid && !bus_i.rd_wr_n && data_oe_i) begin
         mem[bus_i.addr] <= bus_i.wdata;
      end
   end
endmodule : cbs_mem_model

// File: verification/cbs_sequencer_sva.sv
/*
 Port checks of the bus cycle sequencer, bound to every instance.
 Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/10ps
module cbs_sequencer_sva (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic irq_i,
   input wire cbs_pkg::cbs_bus_t bus_o,
   input wire logic addr_oe_o,
   input wire logic data_oe_o,
   input wire logic bus_granted_o,
   input wire logic cc_mask_set_o
);
   import cbs_pkg::*;
   logic vec_hi;
   assign vec_hi = bus_o.valid && bus_o.rd_wr_n &&
      bus_o.addr == SOFT_TRAP_VECTOR;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // ==========================================================
   // Wait state and drive enables
   a_wait_float: assert property (bus_granted_o |-> !addr_oe_o && !data_oe_o)
      else $error("bus not floated in wait");
   a_wait_strobe: assert property (bus_granted_o |-> !bus_o.valid)
      else $error("strobe high in wait");
   a_wait_release: assert property (bus_granted_o && irq_i |-> ##[1:3] !bus_granted_o)
      else $error("wait not left on request");
   a_read_quiet: assert property (bus_o.rd_wr_n |-> !data_oe_o)
      else $error("data driven in a read cycle");
   a_write_drive: assert property (bus_o.valid && !bus_o.rd_wr_n |-> data_oe_o && addr_oe_o)
      else $error("write cycle not driven");
   // ==========================================================
   // Soft trap frame, seen from the vector read backwards and forwards
   a_trap_frame: assert property (vec_hi |-> $past(bus_o.addr, 2) == $past(bus_o.addr, 8) - 16'h0006 && !$past(bus_o.rd_wr_n, 2) && !$past(bus_o.rd_wr_n, 8) && $past(bus_o.valid, 5))
      else $error("trap push frame wrong");
   a_trap_dead: assert property (vec_hi |-> !$past(bus_o.valid) && $past(bus_o.addr) == $past(bus_o.addr, 2) - 16'h0001)
      else $error("trap dead cycle wrong");
   a_trap_discard: assert property (vec_hi |-> $past(bus_o.addr, 9) == $past(bus_o.addr, 10) + 16'h0001 && $past(bus_o.valid, 9) && $past(bus_o.rd_wr_n, 9))
      else $error("trap second cycle wrong");
   a_vector_low: assert property (vec_hi |=> bus_o.valid && bus_o.rd_wr_n && bus_o.addr == 16'hFFFB)
      else $error("vector low byte not read");
   a_mask_pulse: assert property (vec_hi |=> ##[0:2] cc_mask_set_o)
      else $error("mask not set by trap");
   c_wait: cover property (bus_granted_o);
   c_trap: cover property (vec_hi);
   c_write: cover property (bus_o.valid && !bus_o.rd_wr_n);
endmodule : cbs_sequencer_sva
bind cbs_sequencer cbs_sequencer_sva i_cbs_sequencer_sva (.mclk_i, .rst_b_i,
   .irq_i, .bus_o, .addr_oe_o, .data_oe_o, .bus_granted_o, .cc_mask_set_o);

// File: verification/cbs_sequencer_bench.sv
/*
 Self-checking bench of the sequencer, branches included.
 Assumes the memory model answers reads within the cycle shown.
*/
`timescale 1ns/10ps
module cbs_sequencer_bench;
   import cbs_pkg::*;
   typedef struct {
      logic [15:0] at;
      logic [7:0] op, b1, b2;
      int len, ncyc, k;
      logic [15:0] ea;
      logic v, rd;
      logic [15:0] nxt;
   } cbs_row_t;
   // One row per instruction: cycle k must show ea with strobe v, R/W rd.
   cbs_row_t rows [11] = '{
      '{16'h0000, OP_LDX_IMM, 8'h12, 8'h34, 3, 3, 3, 16'h0002, 1, 1, 16'h0003},
      '{16'h0003, OP_LDX_DIR, 8'h40, 8'h00, 2, 4, 4, 16'h0041, 1, 1, 16'h0005},
      '{16'h0005, OP_STA_DIR, 8'h40, 8'h00, 2, 4, 3, 16'h0040, 0, 1, 16'h0007},
      '{16'h0007, OP_STX_DIR, 8'h42, 8'h00, 2, 5, 5, 16'h0043, 1, 0, 16'h0009},
      '{16'h0009, OP_LDX_EXT, 8'h12, 8'h34, 3, 5, 5, 16'h1235, 1, 1, 16'h000C},
      '{16'h000C, OP_STA_EXT, 8'h12, 8'h36, 3, 5, 4, 16'h1236, 0, 1, 16'h000F},
      '{16'h000F, OP_STX_EXT, 8'h12, 8'h38, 3, 6, 6, 16'h1239, 1, 0, 16'h0012},
      '{16'h0012, OP_TEST_EXT, 8'h12, 8'h3A, 3, 6, 5, 16'h123A, 0, 1, 16'h0015},
      '{16'h0015, OP_JUMP_EXT, 8'h00, 8'h20, 3, 3, 3, 16'h0017, 1, 1, 16'h0020},
      '{16'h0020, OP_CALL_EXT, 8'h00, 8'h30, 3, 9, 5, 16'h01FF, 1, 0, 16'h0030},
      '{16'h0030, OP_SOFT_TRAP, 8'h3C, 8'h00, 1, 12, 11, 16'hFFFA, 1, 1, 16'h0050}
   };
   logic [23:0] mem_exp [18] = '{24'h0040A5, 24'h0042C3, 24'h0043E1,
      24'h1236A5, 24'h1238C3, 24'h1239E1, 24'h123A3C, 24'h01FF23, 24'h01FE00,
      24'h01FD31, 24'h01FC00, 24'h01FBE1, 24'h01FAC3, 24'h01F9A5, 24'h01F85B,
      24'h01F7C4, 24'h01F63C, 24'h01F23C};
   // Branch rows: the first falls through, the others are taken.
   cbs_row_t brs [4] = '{
      '{16'h1000, 8'h20, 8'h40, 8'h00, 2, 4, 4, 16'h1042, 0, 1, 16'h1002},
      '{16'h1010, 8'h20, 8'h0F, 8'h00, 2, 4, 4, 16'h1021, 0, 1, 16'h1021},
      '{16'h1021, 8'h20, 8'h80, 8'h00, 2, 4, 4, 16'h0FA3, 0, 1, 16'h0FA3},
      '{16'h0FA3, 8'h20, 8'h7F, 8'h00, 2, 4, 4, 16'h1024, 0, 1, 16'h1024}
   };
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic irq_i = 1'b0;
   logic [7:0] rdata, accum_a_i = 8'hA5;
   logic [15:0] pc_o, sp_o;
   logic take = 1'b1;
   logic addr_oe_o, data_oe_o, bus_granted_o;
   cbs_bus_t bus_o;
   int fail_count = 0, comparisons = 0, cycles = 0, n;
   cbs_sequencer i_cbs_sequencer (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .rdata_i(rdata), .irq_i(irq_i), .branch_take_i(take),
      .accum_a_i(accum_a_i), .accum_b_i(8'h5B), .index_i(16'hC3E1),
      .cc_i(8'hC4), .alu_result_i(8'h77), .bus_o(bus_o),
      .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o),
      .bus_granted_o(bus_granted_o), .pc_o(pc_o), .sp_o(sp_o),
      .operand_o(), .cc_mask_set_o(), .instr_done_o());
   cbs_mem_model i_cbs_mem_model (.mclk_i(mclk_i), .bus_i(bus_o),
      .addr_oe_i(addr_oe_o), .data_oe_i(data_oe_o), .rdata_o(rdata));
   always #5 mclk_i = ~mclk_i;
   // ==========================================================
   // Shared tasks
   task automatic print_verdict();
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [15:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : check
   task automatic run_row(input cbs_row_t r);
      n = 0;
      while (!(bus_o.valid && bus_o.rd_wr_n && bus_o.addr == r.at) && n < 50) begin
         @(negedge mclk_i);
         n++;
      end
      check("fetch", r.at, bus_o.addr);
      for (int i = 2; i <= r.ncyc; i++) begin
         @(negedge mclk_i);
         if (i == r.k) begin
            check("ea", r.ea, bus_o.addr);
            check("ctl", {14'h0, r.v, r.rd}, {14'h0, bus_o.valid, bus_o.rd_wr_n});
         end
      end
      @(negedge mclk_i);
      check("next", r.nxt, bus_o.addr);
   endtask : run_row
   task automatic check_reset();
      @(negedge mclk_i);
      check("rst_ctl", 16'h0001, {14'h0, bus_o.valid, bus_o.rd_wr_n});
      check("rst_pc", RESET_PC, pc_o);
      check("rst_sp", RESET_SP, sp_o);
   endtask : check_reset
   // Hang guard: the whole run needs well under a thousand cycles.
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         print_verdict();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (15) @(posedge mclk_i);
      foreach (rows[j]) begin
         i_cbs_mem_model.mem[rows[j].at] = rows[j].op;
         i_cbs_mem_model.mem[rows[j].at + 16'h1] = rows[j].b1;
         if (rows[j].len == 3) begin
            i_cbs_mem_model.mem[rows[j].at + 16'h2] = rows[j].b2;
         end
      end
      i_cbs_mem_model.mem[16'hFFFA] = 8'h00;
      i_cbs_mem_model.mem[16'hFFFB] = 8'h50;
      i_cbs_mem_model.mem[16'h0050] = OP_WAIT_INT;
      foreach (brs[j]) begin
         i_cbs_mem_model.mem[brs[j].at] = brs[j].op;
         i_cbs_mem_model.mem[brs[j].at + 16'h1] = brs[j].b1;
      end
      i_cbs_mem_model.mem[16'h1002] = OP_JUMP_EXT;
      i_cbs_mem_model.mem[16'h1003] = 8'h10;
      i_cbs_mem_model.mem[16'h1004] = 8'h10;
      check_reset();
      @(posedge mclk_i);
      rst_b_i <= 1'b1;
      foreach (rows[j]) begin
         run_row(rows[j]);
      end
      check("sp", 16'h01F6, sp_o);
      @(posedge mclk_i);
      accum_a_i <= 8'h96;
      n = 0;
      while (bus_granted_o !== 1'b1 && n < 40) begin
         @(negedge mclk_i);
         n++;
      end
      check("granted", 16'h0001, {15'h0, bus_granted_o});
      check("float", 16'h0000, {13'h0, addr_oe_o, data_oe_o, bus_o.valid});
      @(posedge mclk_i);
      irq_i <= 1'b1;
      repeat (4) @(negedge mclk_i);
      check("release", 16'h0000, {15'h0, bus_granted_o});
      @(posedge mclk_i);
      irq_i <= 1'b0;
      foreach (mem_exp[j]) begin
         check("mem", {8'h00, mem_exp[j][7:0]}, {8'h00, i_cbs_mem_model.mem[mem_exp[j][23:8]]});
      end
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      i_cbs_mem_model.mem[16'h0003] = OP_JUMP_EXT;
      i_cbs_mem_model.mem[16'h0004] = 8'h10;
      i_cbs_mem_model.mem[16'h0005] = 8'h00;
      @(posedge mclk_i);
      check_reset();
      @(posedge mclk_i);
      rst_b_i <= 1'b1;
      run_row(rows[0]);
      @(posedge mclk_i);
      take <= 1'b0;
      run_row(brs[0]);
      @(posedge mclk_i);
      take <= 1'b1;
      for (int j = 1; j < 4; j++) begin
         run_row(brs[j]);
      end
      print_verdict();
   end
endmodule : cbs_sequencer_bench
